// File: bench/chc_regs_tb.sv
// self-checking testbench for the calibration hold control register bank
// assumes chc_pkg and chc_regs are compiled first; one 125 MHz clock
`timescale 1ns/1ns
module chc_regs_tb;
  import chc_pkg::*;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic                    clk_i             = 1'b0;
  logic                    rst_i             = 1'b1;
  chc_bus_req_s            bus_i             = '0;
  logic [7:0]              rdata_o;
  logic [LINE_COUNT_W-1:0] line_count_i      = 12'hA5C;
  logic                    hsync_pin_i       = 1'b0;
  logic                    green_sync_pin_i  = 1'b0;
  logic                    offset_auto_en_i  = 1'b1;
  logic [7:0]              offset_interval_i = 8'h01;
  logic [7:0]              gain_interval_i   = 8'h01;
  logic [CAL_W-1:0]        offset_estimate_i = '0;
  logic [CAL_W-1:0]        gain_estimate_i   = '0;
  logic                    green_sync_o;
  logic                    osc_low_gear_o;
  logic [CAL_W-1:0]        offset_value_o;
  logic                    offset_settled_o;
  logic [CAL_W-1:0]        gain_value_o;
  logic                    gain_settled_o;
  int                      fails             = 0;
  int                      total_checks      = 0;
  int                      cycles            = 0;
  logic [31:0]             seed              = 32'd71998;
  logic [7:0]              exp_q[$];
  logic                    rd_q              = 1'b0;
  logic                    seen;
  logic [CAL_W-1:0]        est;
  logic [7:0]              rv;
  logic [7:0]              reset_addrs[11] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D,
                                               8'h2E, 8'h34, 8'h36, 8'h3C, 8'h50};

  always #4 clk_i = ~clk_i;

  chc_regs dut (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .bus_i             (bus_i),
    .rdata_o           (rdata_o),
    .line_count_i      (line_count_i),
    .hsync_pin_i       (hsync_pin_i),
    .green_sync_pin_i  (green_sync_pin_i),
    .offset_auto_en_i  (offset_auto_en_i),
    .offset_interval_i (offset_interval_i),
    .gain_interval_i   (gain_interval_i),
    .offset_estimate_i (offset_estimate_i),
    .gain_estimate_i   (gain_estimate_i),
    .green_sync_o      (green_sync_o),
    .osc_low_gear_o    (osc_low_gear_o),
    .offset_value_o    (offset_value_o),
    .offset_settled_o  (offset_settled_o),
    .gain_value_o      (gain_value_o),
    .gain_settled_o    (gain_settled_o)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // one bus cycle; a read notes its expected data for the monitor
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, wr: w, rd: r};
    if (r) exp_q.push_back(d);
  endtask : op

  task automatic idle();
    @(posedge clk_i);
    bus_i <= '0;
  endtask : idle

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  // n horizontal sync pulses on the pin, then time for the last update to land
  task automatic hs(input int n);
    repeat (n) begin
      @(posedge clk_i);
      hsync_pin_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      hsync_pin_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    settle(6);
  endtask : hs

  // one green pulse of n cycles; reports whether the output ever went high
  task automatic green(input int n, output logic hit);
    hit = 1'b0;
    @(posedge clk_i);
    green_sync_pin_i <= 1'b1;
    for (int i = 0; i < n + 45; i++) begin
      @(posedge clk_i);
      if (i == n - 1) green_sync_pin_i <= 1'b0;
      if (green_sync_o === 1'b1) hit = 1'b1;
    end
  endtask : green

  // ------------------------------------------------------------------
  // read data monitor and timeout
  // ------------------------------------------------------------------
  always @(posedge clk_i) rd_q <= bus_i.rd;

  always @(negedge clk_i) begin
    if (rd_q) begin
      if (exp_q.size() == 0)
        check("read queue", 16'h0001, 16'h0000);
      else
        check("rdata", 16'(rdata_o), 16'(exp_q.pop_front()));
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 6000) begin
      fails++;
      summarize();
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, reserved and unmapped places
    foreach (reset_addrs[i])
      op(1'b0, 1'b1, reset_addrs[i], 8'h00);
    // live line count split over two registers
    line_count_i <= 12'(xs());
    idle();
    op(1'b0, 1'b1, ADDR_LINE_COUNT_HIGH, line_count_i[11:4]);
    op(1'b0, 1'b1, ADDR_LINE_COUNT_LOW, {line_count_i[3:0], 4'h0});
    op(1'b1, 1'b0, ADDR_LINE_COUNT_LOW, 8'hFF);
    op(1'b0, 1'b1, ADDR_LINE_COUNT_LOW, {line_count_i[3:0], 4'h0});
    // mandatory test values back to back, then reserved writes ignored
    op(1'b1, 1'b0, ADDR_TEST_VALUE_ONE, 8'hBF);
    op(1'b1, 1'b0, ADDR_TEST_VALUE_TWO, 8'h02);
    op(1'b1, 1'b0, ADDR_TEST_VALUE_FIVE, 8'hE8);
    op(1'b1, 1'b0, ADDR_TEST_VALUE_SIX, 8'hE0);
    op(1'b1, 1'b0, ADDR_RESERVED_THREE, 8'hFF);
    op(1'b1, 1'b0, ADDR_RESERVED_FOUR, 8'hA5);
    op(1'b0, 1'b1, ADDR_TEST_VALUE_ONE, 8'hBF);
    op(1'b0, 1'b1, ADDR_TEST_VALUE_TWO, 8'h02);
    op(1'b0, 1'b1, ADDR_TEST_VALUE_FIVE, 8'hE8);
    op(1'b0, 1'b1, ADDR_TEST_VALUE_SIX, 8'hE0);
    op(1'b0, 1'b1, ADDR_RESERVED_THREE, RESERVED_READ_VALUE);
    op(1'b0, 1'b1, ADDR_RESERVED_FOUR, RESERVED_READ_VALUE);
    rv = 8'(xs());
    op(1'b1, 1'b0, ADDR_TEST_VALUE_SIX, rv);
    op(1'b0, 1'b1, ADDR_TEST_VALUE_SIX, rv);
    // oscillator gear and stored-bit masks
    op(1'b1, 1'b0, ADDR_OSC_GEAR, 8'hFF);
    op(1'b0, 1'b1, ADDR_OSC_GEAR, 8'h01);
    idle();
    settle(1);
    check("osc_low_gear_o", 16'(osc_low_gear_o), 16'h0001);
    op(1'b1, 1'b0, ADDR_OSC_GEAR, 8'h00);
    idle();
    settle(1);
    check("osc_low_gear_o", 16'(osc_low_gear_o), 16'h0000);
    // green filter off passes a short pulse, on blocks it, long pulse passes
    green(10, seen);
    check("green short unfiltered", 16'(seen), 16'h0001);
    op(1'b1, 1'b0, ADDR_GREEN_FILTER, 8'hFF);
    op(1'b0, 1'b1, ADDR_GREEN_FILTER, 8'h04);
    idle();
    green(31, seen);
    check("green short filtered", 16'(seen), 16'h0000);
    green(32, seen);
    check("green long filtered", 16'(seen), 16'h0001);
    // offset loop: nine updates not settled, tenth settled, hold freezes
    est = CAL_W'(xs());
    offset_estimate_i <= est;
    hs(9);
    check("offset_value_o", 16'(offset_value_o), 16'(est));
    check("offset_settled_o", 16'(offset_settled_o), 16'h0000);
    hs(1);
    check("offset_settled_o", 16'(offset_settled_o), 16'h0001);
    op(1'b1, 1'b0, ADDR_OFFSET_HOLD, 8'h10);
    op(1'b0, 1'b1, ADDR_OFFSET_HOLD, 8'h10);
    idle();
    offset_estimate_i <= ~est;
    hs(3);
    check("offset_value_o held", 16'(offset_value_o), 16'(est));
    check("offset_settled_o held", 16'(offset_settled_o), 16'h0000);
    op(1'b1, 1'b0, ADDR_OFFSET_HOLD, 8'h00);
    idle();
    hs(1);
    check("offset_value_o resumed", 16'(offset_value_o), 16'(CAL_W'(~est)));
    // a longer interval skips one tick; auto offset off freezes the loop
    offset_interval_i <= 8'h02;
    offset_estimate_i <= est;
    hs(1);
    check("offset_value_o interval", 16'(offset_value_o), 16'(CAL_W'(~est)));
    hs(1);
    check("offset_value_o interval", 16'(offset_value_o), 16'(est));
    offset_auto_en_i  <= 1'b0;
    offset_estimate_i <= ~est;
    hs(1);
    check("offset_value_o auto off", 16'(offset_value_o), 16'(est));
    // gain loop: off after reset, runs only with code 110 and hold one
    est = CAL_W'(xs());
    gain_estimate_i <= est;
    hs(2);
    check("gain_value_o off", 16'(gain_value_o), 16'h0000);
    op(1'b1, 1'b0, ADDR_GAIN_MATCH, 8'h0E);
    idle();
    hs(9);
    check("gain_value_o", 16'(gain_value_o), 16'(est));
    check("gain_settled_o", 16'(gain_settled_o), 16'h0000);
    hs(1);
    check("gain_settled_o", 16'(gain_settled_o), 16'h0001);
    op(1'b1, 1'b0, ADDR_GAIN_MATCH, 8'h06);
    op(1'b0, 1'b1, ADDR_GAIN_MATCH, 8'h06);
    idle();
    gain_estimate_i <= ~est;
    hs(2);
    check("gain_value_o frozen", 16'(gain_value_o), 16'(est));
    op(1'b1, 1'b0, ADDR_GAIN_MATCH, 8'h08);
    idle();
    hs(2);
    check("gain_value_o disabled", 16'(gain_value_o), 16'(est));
    check("gain_settled_o disabled", 16'(gain_settled_o), 16'h0000);
    op(1'b1, 1'b0, ADDR_GAIN_MATCH, 8'h0E);
    idle();
    hs(1);
    check("gain_value_o enabled", 16'(gain_value_o), 16'(CAL_W'(~est)));
    settle(3);
    check("pending reads", 16'(exp_q.size()), 16'h0000);
    summarize();
  end

endmodule : chc_regs_tb

// File: core/chc_cal_loop.sv
// one automatic calibration loop with hold and settle tracking
// assumes tick_i is a one-cycle pulse per horizontal sync on clk_i
`timescale 1ns/1ns
module chc_cal_loop
  import chc_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // control
  input  wire logic             run_i,
  input  wire logic             tick_i,
  input  wire logic [7:0]       interval_i,
  input  wire logic [CAL_W-1:0] estimate_i,
  // results
  output logic      [CAL_W-1:0] value_o,
  output logic                  settled_o
);

  // ------------------------------------------------------------------
  // update interval and settle count
  // ------------------------------------------------------------------
  localparam logic [3:0] SETTLE_N = 4'(SETTLE_UPDATES);

  logic [7:0] sync_cnt;
  logic [3:0] upd_cnt;
  wire  [7:0] last_cnt = (interval_i == 8'h00) ? 8'h00 : interval_i - 8'h01;
  wire        update   = run_i && tick_i && (sync_cnt >= last_cnt);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_cnt  <= 8'h00;
      upd_cnt   <= 4'h0;
      value_o   <= '0;
      settled_o <= 1'b0;
    end else if (!run_i) begin
      sync_cnt  <= 8'h00;
      upd_cnt   <= 4'h0;
      settled_o <= 1'b0;
    end else if (update) begin
      sync_cnt  <= 8'h00;
      value_o   <= estimate_i;
      upd_cnt   <= (upd_cnt == SETTLE_N) ? upd_cnt : upd_cnt + 4'h1;
      settled_o <= (upd_cnt >= SETTLE_N - 4'h1);
    end else if (tick_i) begin
      sync_cnt  <= sync_cnt + 8'h01;
    end
  end

  AST_CAL_HOLD_FREEZES: assert property (@(posedge clk_i) disable iff (rst_i)
    (!run_i && $past(!run_i)) |-> $stable(value_o))
    else $error("calibration value moved while held");

  AST_CAL_SETTLE_TEN: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(settled_o) |-> $past(upd_cnt) == 4'h9 && $past(update))
    else $error("settle flag not raised on the tenth update");

endmodule : chc_cal_loop

// File: core/chc_green_filter.sv
// sync-on-green pulse width filter
// assumes its input is already synchronised to clk_i
`timescale 1ns/1ns
module chc_green_filter
  import chc_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic enable_i,
  // sync path
  input  wire logic sync_i,
  output logic      sync_o
);

  // ------------------------------------------------------------------
  // width qualification
  // ------------------------------------------------------------------
  localparam logic [5:0] LAST_CYC = 6'(GREEN_MIN_CYC - 1);

  logic [5:0] run_cnt;
  wire        differs  = (sync_i != sync_o);
  wire        accepted = differs && (run_cnt == LAST_CYC);

  // with the filter enabled, a level must persist for the minimum width before it reaches the pll; disabled, it passes at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_cnt <= 6'h00;
      sync_o  <= 1'b0;
    end else if (!enable_i) begin
      run_cnt <= 6'h00;
      sync_o  <= sync_i;
    end else if (!differs || accepted) begin
      run_cnt <= 6'h00;
      sync_o  <= accepted ? sync_i : sync_o;
    end else begin
      run_cnt <= run_cnt + 6'h01;
    end
  end

  AST_GREEN_NARROW_BLOCKED: assert property (@(posedge clk_i) disable iff (rst_i)
    (enable_i && $past(enable_i) && $changed(sync_o)) |->
      ($past(sync_i, 1) == sync_o) && ($past(sync_i, 32) == sync_o) &&
      ($past(sync_i, 2) == sync_o))
    else $error("green sync passed a pulse narrower than the minimum");

endmodule : chc_green_filter

// File: core/chc_pkg.sv
// package for the calibration and hold control register bank
// assumes one 125 MHz clock and a plain address/strobe register port
package chc_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_LINE_COUNT_HIGH  = 8'h26;
  localparam logic [7:0] ADDR_LINE_COUNT_LOW   = 8'h27;
  localparam logic [7:0] ADDR_TEST_VALUE_ONE   = 8'h28;
  localparam logic [7:0] ADDR_TEST_VALUE_TWO   = 8'h29;
  localparam logic [7:0] ADDR_RESERVED_THREE   = 8'h2A;
  localparam logic [7:0] ADDR_RESERVED_FOUR    = 8'h2B;
  localparam logic [7:0] ADDR_OFFSET_HOLD      = 8'h2C;
  localparam logic [7:0] ADDR_TEST_VALUE_FIVE  = 8'h2D;
  localparam logic [7:0] ADDR_TEST_VALUE_SIX   = 8'h2E;
  localparam logic [7:0] ADDR_GREEN_FILTER     = 8'h34;
  localparam logic [7:0] ADDR_OSC_GEAR         = 8'h36;
  localparam logic [7:0] ADDR_GAIN_MATCH       = 8'h3C;

  // ------------------------------------------------------------------
  // field positions and codes
  // ------------------------------------------------------------------
  localparam int         LINE_COUNT_W          = 12;
  localparam int         LINE_LOW_MSB          = 7;
  localparam int         LINE_LOW_LSB          = 4;
  localparam int         OFFSET_HOLD_BIT       = 4;
  localparam int         GREEN_FILTER_BIT      = 2;
  localparam int         OSC_GEAR_BIT          = 0;
  localparam int         GAIN_HOLD_BIT         = 3;
  localparam int         GAIN_EN_MSB           = 2;
  localparam logic [2:0] GAIN_EN_OFF           = 3'h0;
  localparam logic [2:0] GAIN_EN_ON            = 3'h6;
  localparam logic [7:0] RESERVED_READ_VALUE   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE   = 8'h00;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_TEST_VALUE        = 8'h00;
  localparam logic [7:0] RST_OFFSET_HOLD       = 8'h00;
  localparam logic [7:0] RST_GAIN_MATCH        = 8'h00;
  localparam logic       RST_GREEN_FILTER      = 1'b0;
  localparam logic       RST_OSC_GEAR          = 1'b0;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS         = 8;
  localparam int         GREEN_MIN_PULSE_NS    = 250;
  localparam int         GREEN_MIN_CYC         = (GREEN_MIN_PULSE_NS + CLK_PERIOD_NS - 1)
                                                 / CLK_PERIOD_NS;
  localparam int         SETTLE_UPDATES        = 10;
  localparam int         CAL_W                 = 10;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } chc_bus_req_s;

endpackage : chc_pkg

// File: core/chc_regs.sv
// calibration hold control register bank, top level
// assumes line_count_i and estimates come from logic on clk_i; sync pins are asynchronous
//
// Function
// - 0x27 bits 7:4 show count low nibble
// - 0x26 shows count upper eight bits
// - 0x2A and 0x2B read only, writes ignored
// - offset hold freezes offset loop values
// - offset loop settles within ten updates
// - green filter blocks pulses under 250 ns
// - gear bit selects low oscillator gear
// - gain hold one runs, zero freezes
// - gain loop settles within ten updates
// - gain enable 000 off, 110 on
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module chc_regs
  import chc_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // register port
  input  wire chc_pkg::chc_bus_req_s   bus_i,
  output logic               [7:0]     rdata_o,
  // sync processor and loop inputs
  input  wire logic [chc_pkg::LINE_COUNT_W-1:0] line_count_i,
  input  wire logic                    hsync_pin_i,
  input  wire logic                    green_sync_pin_i,
  input  wire logic                    offset_auto_en_i,
  input  wire logic [7:0]              offset_interval_i,
  input  wire logic [7:0]              gain_interval_i,
  input  wire logic [chc_pkg::CAL_W-1:0] offset_estimate_i,
  input  wire logic [chc_pkg::CAL_W-1:0] gain_estimate_i,
  // controls and results
  output logic                         green_sync_o,
  output logic                         osc_low_gear_o,
  output logic [chc_pkg::CAL_W-1:0]    offset_value_o,
  output logic                         offset_settled_o,
  output logic [chc_pkg::CAL_W-1:0]    gain_value_o,
  output logic                         gain_settled_o
);

  import chc_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic hsync_meta;
  logic hsync_sync;
  logic hsync_prev;
  logic green_meta;
  logic green_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hsync_meta <= 1'b0;
      hsync_sync <= 1'b0;
      hsync_prev <= 1'b0;
      green_meta <= 1'b0;
      green_sync <= 1'b0;
    end else begin
      hsync_meta <= hsync_pin_i;
      hsync_sync <= hsync_meta;
      hsync_prev <= hsync_sync;
      green_meta <= green_sync_pin_i;
      green_sync <= green_meta;
    end
  end

  // one pulse per horizontal sync leading edge
  wire hsync_tick = hsync_sync && !hsync_prev;

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
    hit = (a == want);
  endfunction : hit

  wire wr_test_one   = bus_i.wr && hit(bus_i.addr, ADDR_TEST_VALUE_ONE);
  wire wr_test_two   = bus_i.wr && hit(bus_i.addr, ADDR_TEST_VALUE_TWO);
  wire wr_offset     = bus_i.wr && hit(bus_i.addr, ADDR_OFFSET_HOLD);
  wire wr_test_five  = bus_i.wr && hit(bus_i.addr, ADDR_TEST_VALUE_FIVE);
  wire wr_test_six   = bus_i.wr && hit(bus_i.addr, ADDR_TEST_VALUE_SIX);
  wire wr_green      = bus_i.wr && hit(bus_i.addr, ADDR_GREEN_FILTER);
  wire wr_gear       = bus_i.wr && hit(bus_i.addr, ADDR_OSC_GEAR);
  wire wr_gain       = bus_i.wr && hit(bus_i.addr, ADDR_GAIN_MATCH);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [7:0] test_value_one;
  logic [7:0] test_value_two;
  logic [7:0] offset_hold_control;
  logic [7:0] test_value_five;
  logic [7:0] test_value_six;
  logic       green_filter_en;
  logic       osc_gear;
  logic [7:0] gain_match_control;

  // reserved read registers hold no storage, so writes cannot land
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_value_one      <= RST_TEST_VALUE;
      test_value_two      <= RST_TEST_VALUE;
      offset_hold_control <= RST_OFFSET_HOLD;
      test_value_five     <= RST_TEST_VALUE;
      test_value_six      <= RST_TEST_VALUE;
      green_filter_en     <= RST_GREEN_FILTER;
      osc_gear            <= RST_OSC_GEAR;
      gain_match_control  <= RST_GAIN_MATCH;
    end else begin
      if (wr_test_one) begin
        test_value_one <= bus_i.wdata;
      end
      if (wr_test_two) begin
        test_value_two <= bus_i.wdata;
      end
      if (wr_offset) begin
        offset_hold_control <= bus_i.wdata;
      end
      if (wr_test_five) begin
        test_value_five <= bus_i.wdata;
      end
      if (wr_test_six) begin
        test_value_six <= bus_i.wdata;
      end
      if (wr_green) begin
        green_filter_en <= bus_i.wdata[GREEN_FILTER_BIT];
      end
      if (wr_gear) begin
        osc_gear <= bus_i.wdata[OSC_GEAR_BIT];
      end
      if (wr_gain) begin
        gain_match_control <= bus_i.wdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // loop control decode
  // ------------------------------------------------------------------
  wire [2:0] gain_en_field = gain_match_control[GAIN_EN_MSB:0];
  // codes other than the enable code leave gain matching off
  wire       gain_enabled  = (gain_en_field == GAIN_EN_ON);
  wire       gain_run      = gain_enabled && gain_match_control[GAIN_HOLD_BIT];
  wire       offset_run    = offset_auto_en_i && !offset_hold_control[OFFSET_HOLD_BIT];

  // ------------------------------------------------------------------
  // calibration loops
  // ------------------------------------------------------------------
  chc_cal_loop u_offset_loop (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (offset_run),
    .tick_i     (hsync_tick),
    .interval_i (offset_interval_i),
    .estimate_i (offset_estimate_i),
    .value_o    (offset_value_o),
    .settled_o  (offset_settled_o)
  );

  chc_cal_loop u_gain_loop (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (gain_run),
    .tick_i     (hsync_tick),
    .interval_i (gain_interval_i),
    .estimate_i (gain_estimate_i),
    .value_o    (gain_value_o),
    .settled_o  (gain_settled_o)
  );

  // ------------------------------------------------------------------
  // green sync filter and gear output
  // ------------------------------------------------------------------
  chc_green_filter u_green_filter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (green_filter_en),
    .sync_i   (green_sync),
    .sync_o   (green_sync_o)
  );

  assign osc_low_gear_o = osc_gear;

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  wire [7:0] line_high_view = line_count_i[LINE_COUNT_W-1:LINE_LOW_LSB];
  wire [7:0] line_low_view  = {line_count_i[LINE_LOW_MSB-LINE_LOW_LSB:0], 4'h0};
  wire [7:0] green_view     = 8'(32'(green_filter_en) << GREEN_FILTER_BIT);
  wire [7:0] gear_view      = 8'(32'(osc_gear) << OSC_GEAR_BIT);

  logic [7:0] read_view;

  always_comb begin
    unique case (bus_i.addr)
      ADDR_LINE_COUNT_HIGH: read_view = line_high_view;
      ADDR_LINE_COUNT_LOW:  read_view = line_low_view;
      ADDR_TEST_VALUE_ONE:  read_view = test_value_one;
      ADDR_TEST_VALUE_TWO:  read_view = test_value_two;
      ADDR_RESERVED_THREE:  read_view = RESERVED_READ_VALUE;
      ADDR_RESERVED_FOUR:   read_view = RESERVED_READ_VALUE;
      ADDR_OFFSET_HOLD:     read_view = offset_hold_control;
      ADDR_TEST_VALUE_FIVE: read_view = test_value_five;
      ADDR_TEST_VALUE_SIX:  read_view = test_value_six;
      ADDR_GREEN_FILTER:    read_view = green_view;
      ADDR_OSC_GEAR:        read_view = gear_view;
      ADDR_GAIN_MATCH:      read_view = gain_match_control;
      default:              read_view = UNMAPPED_READ_VALUE;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= bus_i.rd ? read_view : 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_LINE_LOW_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_i.rd && bus_i.addr == ADDR_LINE_COUNT_LOW) |=>
      rdata_o == {$past(line_count_i[3:0]), 4'h0})
    else $error("low count read does not show the low nibble");

  AST_LINE_HIGH_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_i.rd && bus_i.addr == ADDR_LINE_COUNT_HIGH) |=>
      rdata_o == $past(line_count_i[11:4]))
    else $error("high count read does not show the upper bits");

  AST_RESERVED_READ_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_i.rd && (bus_i.addr == ADDR_RESERVED_THREE || bus_i.addr == ADDR_RESERVED_FOUR))
      |=> rdata_o == 8'h00)
    else $error("reserved register read back a written value");

  AST_OFFSET_HOLD_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
    (offset_hold_control[OFFSET_HOLD_BIT] && $past(offset_hold_control[OFFSET_HOLD_BIT]))
      |-> $stable(offset_value_o))
    else $error("offset value changed while hold is set");

  AST_GAIN_HOLD_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!gain_match_control[GAIN_HOLD_BIT] && $past(!gain_match_control[GAIN_HOLD_BIT]))
      |-> $stable(gain_value_o))
    else $error("gain value changed while hold is clear");

  AST_GAIN_ENABLE_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
    (gain_en_field == GAIN_EN_OFF) |-> !gain_run ##1 (gain_settled_o == 1'b0))
    else $error("gain loop running with enable field off");

  AST_GEAR_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_gear |=> osc_low_gear_o == $past(bus_i.wdata[OSC_GEAR_BIT]))
    else $error("gear output does not follow the written bit");

  AST_GREEN_DEFAULT_OFF: assert property (@(posedge clk_i)
    $past(rst_i) |-> !green_filter_en)
    else $error("green filter not off after reset");

  AST_GREEN_ENABLE_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_green |=> green_filter_en == $past(bus_i.wdata[GREEN_FILTER_BIT]))
    else $error("green filter enable does not take the written bit");

  AST_GEAR_STEADY: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_gear |=> $stable(osc_low_gear_o))
    else $error("gear output moved without a write");

  AST_OFFSET_RUN_UPDATES: assert property (@(posedge clk_i) disable iff (rst_i)
    (offset_run && hsync_tick && offset_interval_i == 8'h01) |=>
      offset_value_o == $past(offset_estimate_i))
    else $error("running offset loop did not take the estimate");

  AST_GAIN_RUN_UPDATES: assert property (@(posedge clk_i) disable iff (rst_i)
    (gain_run && hsync_tick && gain_interval_i == 8'h01) |=>
      gain_value_o == $past(gain_estimate_i))
    else $error("running gain loop did not take the estimate");

  AST_GAIN_CODE_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
    (gain_en_field != GAIN_EN_ON && $past(gain_en_field != GAIN_EN_ON))
      |-> $stable(gain_value_o))
    else $error("gain value moved without the enable code");

  AST_OFFSET_SETTLED_DROPS: assert property (@(posedge clk_i) disable iff (rst_i)
    !offset_run |=> !offset_settled_o)
    else $error("offset settle flag stayed up after the loop stopped");

endmodule : chc_regs
